// ---- core/pxr_defs.vh ----
// Constants for the palette and extended register port
`ifndef PXR_DEFS_VH
`define PXR_DEFS_VH
// Host I/O port addresses
`define PXR_PORT_EXT_INDEX 16'h03c4
`define PXR_PORT_EXT_DATA 16'h03c5
`define PXR_PORT_PIXEL_MASK 16'h03c6
`define PXR_PORT_PAL_RD_INDEX 16'h03c7
`define PXR_PORT_PAL_WR_INDEX 16'h03c8
`define PXR_PORT_PAL_DATA 16'h03c9
// Extended register indices
`define PXR_IDX_PASSWORD 6'h05
`define PXR_IDX_GFX_MODE 6'h06
`define PXR_IDX_MISC0 6'h07
`define PXR_IDX_THRESH_A 6'h08
`define PXR_IDX_THRESH_B 6'h09
`define PXR_IDX_CRT_OVF 6'h0a
`define PXR_IDX_MISC1 6'h0b
`define PXR_IDX_MISC2 6'h0c
// Password and identification values (identification values arbitrary)
`define PXR_UNLOCK_KEY 8'h86
`define PXR_ID_UNLOCKED 8'h5a
`define PXR_ID_LOCKED 8'h3c
// Reset values
`define PXR_RST_REG 8'h00
`define PXR_RST_INDEX 8'h00
// Palette state codes
`define PXR_STATE_WRITE 2'b00
`define PXR_STATE_READ 2'b11
// Field positions
`define PXR_MISC0_PAL24_N 2
`define PXR_EXT_INDEX_W 6
`endif

// ---- core/pxr_port.v ----
// Palette lookup table port and locked extended register file
`timescale 1ns/1ps
// How it works
// - Palette state reads 00 during write sequence, 11 during read sequence.
// - Write index, then red, green, blue; third stores entry and bumps index.
// - Read index, then three reads; third read bumps the index.
// - Palette bit set: data is six bits, top two read zero.
// - Palette bit clear: full eight-bit data per colour.
// - Pixel bits masked by zero mask bits are ignored in lookup.
// - Extended index is six bits selecting the data port register.
// - Writing the key unlocks; password reads unlocked identification.
// - Writing any other value locks; password reads locked identification.
// - Graphics mode control bits each enable one feature.
// - Misc zero bit 7 merges line buffer into CRT FIFO, no playback.
// - Misc zero bits 3 and 2 are active-low enables.
// - Misc zero bits 6,5,4,0 drive connector, power, clock halve, vref.
// - Threshold registers each hold two four-bit fields.
// - CRT overflow gives offset 11:8 and four vertical bit-10s.
// - Misc one bit 7 selects true-colour byte order.
// - Misc one bits 6:5 select memory-mapped I/O window.
// - Misc one bits 4..0 are individual enables.
// - Misc two bits 7,6,5,3 are individual enables.
// - Misc two bits 2:1 encode memory configuration.
`include "pxr_defs.vh"
module pxr_port (
   input wire core_clk_i,
   input wire arst_n_i,
   input wire [15:0] io_addr_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] pixel_i,
   output reg [7:0] io_rdata_o,
   output reg [23:0] lut_rgb_o,
   output reg [7:0] gfx_mode_o,
   output reg [7:0] misc0_o,
   output reg [7:0] thresh_a_o,
   output reg [7:0] thresh_b_o,
   output reg [7:0] crt_ovf_o,
   output reg [7:0] misc1_o,
   output reg [7:0] misc2_o,
   output reg unlocked_o
);
   // ----------------------------------------------------------------
   // Storage and state
   // ----------------------------------------------------------------
   localparam SEQ_R = 3'b001;
   localparam SEQ_G = 3'b010;
   localparam SEQ_B = 3'b100;
   reg [23:0] lut_q [0:255];
   reg [7:0] wr_index_q;
   reg [7:0] rd_index_q;
   reg [2:0] wr_seq_q;
   reg [2:0] rd_seq_q;
   reg [7:0] red_q;
   reg [7:0] green_q;
   reg read_mode_q;
   reg [7:0] pixel_mask_q;
   reg [7:0] ext_index_q;
   reg [7:0] id_q;
   integer i;

   wire pal6 = misc0_o[`PXR_MISC0_PAL24_N];
   wire [5:0] ext_idx = ext_index_q[`PXR_EXT_INDEX_W-1:0];
   wire wr_ext = io_wr_i && io_addr_i == `PXR_PORT_EXT_DATA;
   wire pw_write = wr_ext && ext_idx == `PXR_IDX_PASSWORD;
   wire ext_wr_ok = wr_ext && unlocked_o;

   // Trim data to the active palette width
   function [7:0] pal_trim;
      input [7:0] v;
      input six;
      begin
         pal_trim = six ? {2'b00, v[5:0]} : v;
      end
   endfunction

   // ----------------------------------------------------------------
   // Palette sequencer
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         wr_index_q <= `PXR_RST_INDEX;
         rd_index_q <= `PXR_RST_INDEX;
         wr_seq_q <= SEQ_R;
         rd_seq_q <= SEQ_R;
         red_q <= `PXR_RST_REG;
         green_q <= `PXR_RST_REG;
         read_mode_q <= 1'b0;
         pixel_mask_q <= `PXR_RST_REG;
         for (i = 0; i < 256; i = i + 1) begin
            lut_q[i] <= 24'h000000;
         end
      end else begin
         if (io_wr_i && io_addr_i == `PXR_PORT_PIXEL_MASK) begin
            pixel_mask_q <= io_wdata_i;
         end
         if (io_wr_i && io_addr_i == `PXR_PORT_PAL_WR_INDEX) begin
            wr_index_q <= io_wdata_i;
            wr_seq_q <= SEQ_R;
            read_mode_q <= 1'b0;
         end
         if (io_wr_i && io_addr_i == `PXR_PORT_PAL_RD_INDEX) begin
            rd_index_q <= io_wdata_i;
            rd_seq_q <= SEQ_R;
            read_mode_q <= 1'b1;
         end
         if (io_wr_i && io_addr_i == `PXR_PORT_PAL_DATA) begin
            case (wr_seq_q)
               SEQ_R: begin
                  red_q <= pal_trim(io_wdata_i, pal6);
                  wr_seq_q <= SEQ_G;
               end
               SEQ_G: begin
                  green_q <= pal_trim(io_wdata_i, pal6);
                  wr_seq_q <= SEQ_B;
               end
               SEQ_B: begin
                  lut_q[wr_index_q] <= {red_q, green_q, pal_trim(io_wdata_i, pal6)};
                  wr_index_q <= wr_index_q + 8'h01;
                  wr_seq_q <= SEQ_R;
               end
               default: begin
                  wr_seq_q <= SEQ_R;
               end
            endcase
         end
         if (io_rd_i && io_addr_i == `PXR_PORT_PAL_DATA) begin
            case (rd_seq_q)
               SEQ_R: begin
                  rd_seq_q <= SEQ_G;
               end
               SEQ_G: begin
                  rd_seq_q <= SEQ_B;
               end
               SEQ_B: begin
                  rd_index_q <= rd_index_q + 8'h01;
                  rd_seq_q <= SEQ_R;
               end
               default: begin
                  rd_seq_q <= SEQ_R;
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Extended register file
   // ----------------------------------------------------------------
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         ext_index_q <= `PXR_RST_INDEX;
         id_q <= `PXR_ID_LOCKED;
         unlocked_o <= 1'b0;
         gfx_mode_o <= `PXR_RST_REG;
         misc0_o <= `PXR_RST_REG;
         thresh_a_o <= `PXR_RST_REG;
         thresh_b_o <= `PXR_RST_REG;
         crt_ovf_o <= `PXR_RST_REG;
         misc1_o <= `PXR_RST_REG;
         misc2_o <= `PXR_RST_REG;
      end else begin
         if (io_wr_i && io_addr_i == `PXR_PORT_EXT_INDEX) begin
            ext_index_q <= {2'b00, io_wdata_i[5:0]};
         end
         if (pw_write) begin
            if (io_wdata_i == `PXR_UNLOCK_KEY) begin
               unlocked_o <= 1'b1;
               id_q <= `PXR_ID_UNLOCKED;
            end else begin
               unlocked_o <= 1'b0;
               id_q <= `PXR_ID_LOCKED;
            end
         end
         if (ext_wr_ok) begin
            case (ext_idx)
               `PXR_IDX_GFX_MODE: gfx_mode_o <= io_wdata_i;
               `PXR_IDX_MISC0: misc0_o <= io_wdata_i;
               `PXR_IDX_THRESH_A: thresh_a_o <= io_wdata_i;
               `PXR_IDX_THRESH_B: thresh_b_o <= io_wdata_i;
               `PXR_IDX_CRT_OVF: crt_ovf_o <= io_wdata_i;
               `PXR_IDX_MISC1: misc1_o <= io_wdata_i;
               `PXR_IDX_MISC2: misc2_o <= io_wdata_i;
               default: begin
               end
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // Read data and lookup output
   // ----------------------------------------------------------------
   reg [7:0] rdata_d;
   reg [23:0] rd_entry;
   always @* begin
      rd_entry = lut_q[rd_index_q];
      rdata_d = 8'h00;
      case (io_addr_i)
         `PXR_PORT_EXT_INDEX: rdata_d = ext_index_q;
         `PXR_PORT_PIXEL_MASK: rdata_d = pixel_mask_q;
         `PXR_PORT_PAL_RD_INDEX:
            rdata_d = read_mode_q ? {6'h00, `PXR_STATE_READ} : {6'h00, `PXR_STATE_WRITE};
         `PXR_PORT_PAL_WR_INDEX: rdata_d = wr_index_q;
         `PXR_PORT_PAL_DATA: begin
            if (rd_seq_q == SEQ_R) begin
               rdata_d = pal_trim(rd_entry[23:16], pal6);
            end else if (rd_seq_q == SEQ_G) begin
               rdata_d = pal_trim(rd_entry[15:8], pal6);
            end else begin
               rdata_d = pal_trim(rd_entry[7:0], pal6);
            end
         end
         `PXR_PORT_EXT_DATA: begin
            if (ext_idx == `PXR_IDX_PASSWORD) begin
               rdata_d = id_q;
            end else if (unlocked_o) begin
               case (ext_idx)
                  `PXR_IDX_GFX_MODE: rdata_d = gfx_mode_o;
                  `PXR_IDX_MISC0: rdata_d = misc0_o;
                  `PXR_IDX_THRESH_A: rdata_d = thresh_a_o;
                  `PXR_IDX_THRESH_B: rdata_d = thresh_b_o;
                  `PXR_IDX_CRT_OVF: rdata_d = crt_ovf_o;
                  `PXR_IDX_MISC1: rdata_d = misc1_o;
                  `PXR_IDX_MISC2: rdata_d = misc2_o;
                  default: rdata_d = 8'h00;
               endcase
            end else begin
               rdata_d = 8'h00;
            end
         end
         default: rdata_d = 8'h00;
      endcase
   end

   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         io_rdata_o <= 8'h00;
         lut_rgb_o <= 24'h000000;
      end else begin
         if (io_rd_i) begin
            io_rdata_o <= rdata_d;
         end
         lut_rgb_o <= lut_q[pixel_i & pixel_mask_q];
      end
   end
endmodule

// ---- test/pxr_host.sv ----
// Host processor model issuing I/O port accesses
`timescale 1ns/1ps
module pxr_host (
   input wire core_clk_i,
   output reg [15:0] io_addr_o = 16'h0000,
   output reg io_wr_o = 1'b0,
   output reg io_rd_o = 1'b0,
   output reg [7:0] io_wdata_o = 8'h00
);
   // One strobe cycle per access, never write and read together
   task acc(input w, input [15:0] a, input [7:0] d);
      begin
         io_wr_o = w;
         io_rd_o = !w;
         io_addr_o = a;
         io_wdata_o = d;
         @(posedge core_clk_i);
         #2;
      end
   endtask
   // Released bus shows inverted values
   task idle;
      begin
         io_wr_o = 1'b0;
         io_rd_o = 1'b0;
         io_addr_o = ~io_addr_o;
         io_wdata_o = ~io_wdata_o;
         @(posedge core_clk_i);
         #2;
      end
   endtask
endmodule

// ---- test/pxr_port_monitor.sv ----
// Concurrent checks on the palette and extended register port
`timescale 1ns/1ps
`include "pxr_defs.vh"
module pxr_port_monitor (
   input wire core_clk_i,
   input wire arst_n_i,
   input wire [15:0] io_addr_i,
   input wire io_wr_i,
   input wire io_rd_i,
   input wire [7:0] io_wdata_i,
   input wire [7:0] io_rdata_o,
   input wire [7:0] gfx_mode_o,
   input wire [7:0] misc0_o,
   input wire unlocked_o
);
   reg [5:0] idx_q;
   reg rdm_q;
   wire we = io_wr_i && io_addr_i == `PXR_PORT_EXT_DATA;
   wire re = io_rd_i && io_addr_i == `PXR_PORT_EXT_DATA;
   wire pw = idx_q == `PXR_IDX_PASSWORD;
   wire pix = io_addr_i == `PXR_PORT_PAL_RD_INDEX || io_addr_i == `PXR_PORT_PAL_WR_INDEX;
   // Shadow of the extended index and the palette sequence direction
   always @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         idx_q <= 6'h00;
         rdm_q <= 1'b0;
      end else if (io_wr_i) begin
         if (io_addr_i == `PXR_PORT_EXT_INDEX) idx_q <= io_wdata_i[5:0];
         if (pix) rdm_q <= io_addr_i == `PXR_PORT_PAL_RD_INDEX;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!arst_n_i);
   sequence s_wr_idx; io_wr_i && io_addr_i == `PXR_PORT_PAL_WR_INDEX; endsequence
   sequence s_rd_idx; io_rd_i && io_addr_i == `PXR_PORT_PAL_WR_INDEX; endsequence
   AST_UNLOCK: assert property (
      we && pw && io_wdata_i == `PXR_UNLOCK_KEY |=> unlocked_o) else $error("unlock missed");
   AST_LOCK: assert property (
      we && pw && io_wdata_i != `PXR_UNLOCK_KEY |=> !unlocked_o) else $error("lock missed");
   AST_PASSWORD_ID: assert property (
      re && pw |=> io_rdata_o == (unlocked_o ? `PXR_ID_UNLOCKED : `PXR_ID_LOCKED))
      else $error("wrong identification");
   AST_LOCKED_IGNORE: assert property (
      we && !unlocked_o && !pw |=> $stable(gfx_mode_o) && $stable(misc0_o))
      else $error("locked write took effect");
   AST_GFX_WRITE: assert property (
      we && unlocked_o && idx_q == `PXR_IDX_GFX_MODE |=> gfx_mode_o == $past(io_wdata_i))
      else $error("mode write lost");
   AST_INDEX_READ: assert property (
      io_rd_i && io_addr_i == `PXR_PORT_EXT_INDEX |=> io_rdata_o == {2'b00, idx_q})
      else $error("index readback wrong");
   AST_STATE_READ: assert property (
      io_rd_i && io_addr_i == `PXR_PORT_PAL_RD_INDEX |=> io_rdata_o[1:0] == {2{rdm_q}})
      else $error("palette state wrong");
   AST_WR_INDEX_BACK: assert property (
      s_wr_idx ##1 s_rd_idx |=> io_rdata_o == $past(io_wdata_i, 2))
      else $error("write index readback wrong");
endmodule
bind pxr_port pxr_port_monitor u_mon (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
   .io_addr_i(io_addr_i), .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i),
   .io_rdata_o(io_rdata_o), .gfx_mode_o(gfx_mode_o), .misc0_o(misc0_o),
   .unlocked_o(unlocked_o));

// ---- test/tb.sv ----
// Self-checking testbench for the palette and extended register port
`timescale 1ns/1ps
`include "pxr_defs.vh"
module tb;
   reg core_clk_i = 1'b0;
   reg arst_n_i = 1'b0;
   reg [7:0] pixel_i = 8'h00;
   wire [15:0] io_addr_i;
   wire io_wr_i, io_rd_i, unlocked_o;
   wire [7:0] io_wdata_i, io_rdata_o, gfx_o, m0_o, ta_o, tb_o, crt_o, m1_o, m2_o;
   wire [23:0] lut_rgb_o;
   integer num_errors = 0;
   integer comparisons = 0;
   integer i;
   reg [7:0] exp_q[$];
   reg [7:0] v[0:6];
   reg [7:0] r, g, b;
   always #5 core_clk_i = ~core_clk_i;
   pxr_host u_host (.core_clk_i(core_clk_i), .io_addr_o(io_addr_i), .io_wr_o(io_wr_i),
      .io_rd_o(io_rd_i), .io_wdata_o(io_wdata_i));
   pxr_port u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .io_addr_i(io_addr_i),
      .io_wr_i(io_wr_i), .io_rd_i(io_rd_i), .io_wdata_i(io_wdata_i), .pixel_i(pixel_i),
      .io_rdata_o(io_rdata_o), .lut_rgb_o(lut_rgb_o), .gfx_mode_o(gfx_o), .misc0_o(m0_o),
      .thresh_a_o(ta_o), .thresh_b_o(tb_o), .crt_ovf_o(crt_o), .misc1_o(m1_o),
      .misc2_o(m2_o), .unlocked_o(unlocked_o));
   task check(input [63:0] got, input [63:0] exp);
      begin
         comparisons = comparisons + 1;
         if (got !== exp) begin
            num_errors = num_errors + 1;
            $display("Error %0t: got %h expected %h", $time, got, exp);
         end
      end
   endtask
   task print_verdict;
      begin
         $display("Comparisons %0d, errors %0d", comparisons, num_errors);
         if (num_errors == 0 && comparisons > 0) $display("All checks passed");
         else $display("Checks failed");
         $finish;
      end
   endtask
   task wr(input [15:0] a, input [7:0] d);
      u_host.acc(1'b1, a, d);
   endtask
   task rd(input [15:0] a, input [7:0] e);
      begin
         exp_q.push_back(e);
         u_host.acc(1'b0, a, 8'h00);
      end
   endtask
   task xw(input [5:0] x, input [7:0] d);
      begin
         wr(`PXR_PORT_EXT_INDEX, {2'b00, x});
         wr(`PXR_PORT_EXT_DATA, d);
      end
   endtask
   // Read data is registered at the edge that samples the read strobe
   always @(posedge core_clk_i) begin
      #1;
      if (io_rd_i && exp_q.size() > 0) check(io_rdata_o, exp_q.pop_front());
      else if (io_rd_i) check(1, 0);
   end
   initial begin
      #100000;
      $display("Error %0t: run timed out", $time);
      num_errors = num_errors + 1;
      print_verdict;
   end
   initial begin
      void'($urandom(47352));
      repeat (4) @(posedge core_clk_i);
      #2;
      arst_n_i = 1'b1;
      u_host.idle;
      check({gfx_o, m0_o, ta_o, tb_o, crt_o, m1_o, m2_o, unlocked_o}, 0);
      wr(`PXR_PORT_EXT_INDEX, 8'h05);
      rd(`PXR_PORT_EXT_DATA, `PXR_ID_LOCKED);
      rd(`PXR_PORT_PAL_RD_INDEX, 8'h00);
      xw(`PXR_IDX_GFX_MODE, 8'hff);
      rd(`PXR_PORT_EXT_DATA, 8'h00);
      xw(`PXR_IDX_PASSWORD, `PXR_UNLOCK_KEY);
      rd(`PXR_PORT_EXT_DATA, `PXR_ID_UNLOCKED);
      for (i = 0; i < 7; i = i + 1) begin
         v[i] = $urandom;
         xw(6'h06 + i[5:0], v[i]);
         rd(`PXR_PORT_EXT_DATA, v[i]);
      end
      check({gfx_o, m0_o, ta_o, tb_o, crt_o, m1_o, m2_o}, {v[0], v[1], v[2], v[3], v[4], v[5], v[6]});
      wr(`PXR_PORT_EXT_INDEX, 8'hcd);
      rd(`PXR_PORT_EXT_INDEX, 8'h0d);
      rd(`PXR_PORT_EXT_DATA, 8'h00);
      xw(`PXR_IDX_MISC0, 8'h00);
      r = $urandom;
      g = $urandom;
      b = $urandom;
      wr(`PXR_PORT_PAL_WR_INDEX, 8'hfe);
      rd(`PXR_PORT_PAL_WR_INDEX, 8'hfe);
      wr(`PXR_PORT_PAL_DATA, 8'h11);
      wr(`PXR_PORT_PAL_WR_INDEX, 8'hfe);
      wr(`PXR_PORT_PAL_DATA, r);
      wr(`PXR_PORT_PAL_DATA, g);
      wr(`PXR_PORT_PAL_DATA, b);
      rd(`PXR_PORT_PAL_WR_INDEX, 8'hff);
      rd(`PXR_PORT_PAL_RD_INDEX, 8'h00);
      wr(`PXR_PORT_PAL_RD_INDEX, 8'hfe);
      rd(`PXR_PORT_PAL_DATA, r);
      wr(`PXR_PORT_PAL_RD_INDEX, 8'hfe);
      rd(`PXR_PORT_PAL_DATA, r);
      rd(`PXR_PORT_PAL_DATA, g);
      rd(`PXR_PORT_PAL_DATA, b);
      rd(`PXR_PORT_PAL_DATA, 8'h00);
      rd(`PXR_PORT_PAL_RD_INDEX, 8'h03);
      wr(`PXR_PORT_PIXEL_MASK, 8'hfe);
      rd(`PXR_PORT_PIXEL_MASK, 8'hfe);
      pixel_i = 8'hff;
      u_host.idle;
      u_host.idle;
      check(lut_rgb_o, {r, g, b});
      wr(`PXR_PORT_PIXEL_MASK, 8'h00);
      u_host.idle;
      u_host.idle;
      check(lut_rgb_o, 0);
      xw(`PXR_IDX_MISC0, 8'h04);
      wr(`PXR_PORT_PAL_WR_INDEX, 8'h10);
      for (i = 0; i < 3; i = i + 1) wr(`PXR_PORT_PAL_DATA, 8'hff);
      wr(`PXR_PORT_PAL_RD_INDEX, 8'h10);
      for (i = 0; i < 3; i = i + 1) rd(`PXR_PORT_PAL_DATA, 8'h3f);
      xw(`PXR_IDX_PASSWORD, 8'h00);
      rd(`PXR_PORT_EXT_DATA, `PXR_ID_LOCKED);
      rd(16'h03c0, 8'h00);
      u_host.idle;
      u_host.idle;
      check(unlocked_o, 0);
      print_verdict;
   end
endmodule
